// [dv/serial_line_driver_led_ctrl_tb.sv]
`timescale 1ns/1ps
module serial_line_driver_led_ctrl_tb;
   logic mclk_i = 1'h0;
   logic rst_n_i = 1'h0;
   logic [15:0] addr;
   logic wr, rd, tx485, rx, tx422, led, hit;
   logic [7:0] wdata, rdata, r;
   int err_total = 0;
   int comparisons = 0;
   int cycles = 0;
   initial forever #2 mclk_i = ~mclk_i;
   sldlc_host host(.mclk_i(mclk_i), .addr_o(addr), .wr_o(wr), .rd_o(rd),
      .wdata_o(wdata), .rdata_i(rdata));
   sldlc_top dut(.mclk_i(mclk_i), .rst_n_i(rst_n_i), .io_addr_i(addr),
      .io_wr_i(wr), .io_rd_i(rd), .io_wdata_i(wdata), .io_rdata_o(rdata),
      .io_hit_o(hit), .rs485_tx_enable_o(tx485), .line_rx_enable_o(rx),
      .rs422_tx_enable_o(tx422), .led_on_o(led));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // enables packed as the register lays them out
   function automatic logic [7:0] en();
      return {5'h00, tx485, rx, tx422};
   endfunction
   task automatic end_of_test();
      $display("comparisons=%0d err_total=%0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // write transceiver byte, then check pins one step later
   task automatic xw(input logic [7:0] d, input logic [7:0] exp);
      host.io_wr(16'h01D3, d);
      #1 chk(en(), exp);
   endtask
   task automatic t_bits();
      for (int v = 0; v < 8; v++)
      begin
         xw(8'hF8 | 8'(v), 8'(v));
         host.io_rd(16'h01D3, r);
         chk(r, 8'(v));
      end
      $display("t_bits done");
   endtask
   task automatic t_dir();
      host.fw_init();
      #1 chk(en(), 8'h02);
      xw(8'h06, 8'h06);
      host.led_set(1'h1);
      repeat (20) @(posedge mclk_i);
      chk(en(), 8'h06);
      host.io_rd(16'h01D0, r);
      chk(r, 8'h80);
      xw(8'h02, 8'h02);
      host.led_set(1'h0);
      #1 chk({led, 7'h00}, 8'h00);
      $display("t_dir done");
   endtask
   // other addresses change nothing and read zero; decode seen mid-access
   task automatic t_refused();
      host.io_wr(16'h01D1, 8'hFF);
      #1 chk({led, 7'h00} | en(), 8'h02);
      chk(rdata, 8'h80);
      fork
         host.io_rd(16'h01D2, r);
         begin
            @(posedge mclk_i);
            #1 chk({7'h00, hit}, 8'h00);
         end
      join
      chk(r, 8'h00);
      fork
         host.io_rd(16'h01D3, r);
         begin
            @(posedge mclk_i);
            #1 chk({7'h00, hit}, 8'h01);
         end
      join
      chk(r, 8'h02);
      fork
         host.io_wr(16'h01D0, 8'h7F);
         begin
            @(posedge mclk_i);
            #1 chk({7'h00, hit}, 8'h01);
         end
      join
      #1 chk({led, 7'h00} | rdata, 8'h02);
      host.io_rd(16'h01D0, r);
      chk(r, 8'h00);
      $display("t_refused done");
   endtask
   // mid-run reset drops every enable, the led and the read data
   task automatic t_reset();
      xw(8'h07, 8'h07);
      host.led_set(1'h1);
      host.io_rd(16'h01D3, r);
      chk(r, 8'h07);
      @(posedge mclk_i);
      rst_n_i <= 1'h0;
      #1 chk(rdata | en() | {led, 7'h00}, 8'h00);
      repeat (3) @(posedge mclk_i);
      rst_n_i <= 1'h1;
      #1 chk(rdata | en() | {led, 7'h00}, 8'h00);
      host.fw_init();
      #1 chk(en(), 8'h02);
      host.io_rd(16'h01D0, r);
      chk(r, 8'h00);
      $display("t_reset done");
   endtask
   // hang guard, tests need about a hundred cycles
   always @(posedge mclk_i)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         err_total++;
         end_of_test();
      end
   end
   initial
   begin
      repeat (12) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      #1 chk(rdata | en() | {led, 7'h00}, 8'h00);
      t_bits();
      t_dir();
      t_refused();
      t_reset();
      end_of_test();
   end
endmodule // serial_line_driver_led_ctrl_tb

// [dv/sldlc_host.sv]
`timescale 1ns/1ps
// host model: byte i/o cycles with one-cycle strobes
module sldlc_host
(
   // clock
   input wire logic mclk_i,
   // i/o port cycle
   output logic [15:0] addr_o,
   output logic wr_o,
   output logic rd_o,
   output logic [7:0] wdata_o,
   input wire logic [7:0] rdata_i
);
   initial {addr_o, wr_o, rd_o, wdata_o} = '0;
   // idle bus shows inverted values, never a stale address
   task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'h1;
      @(posedge mclk_i);
      wr_o <= 1'h0;
      addr_o <= ~a;
      wdata_o <= ~d;
   endtask
   // read data lands on the taking edge
   task automatic io_rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge mclk_i);
      addr_o <= a;
      rd_o <= 1'h1;
      @(posedge mclk_i);
      rd_o <= 1'h0;
      addr_o <= ~a;
      #1 d = rdata_i;
   endtask
   // firmware leaves half-duplex line receiving
   task automatic fw_init();
      io_wr(16'h01D3, 8'h02);
   endtask
   // led change keeps the other bits as read
   task automatic led_set(input logic on);
      logic [7:0] v;
      io_rd(16'h01D0, v);
      io_wr(16'h01D0, {on, v[6:0]});
   endtask
endmodule // sldlc_host

// [verilog/sldlc_defines.svh]
`ifndef SLDLC_DEFINES_SVH
`define SLDLC_DEFINES_SVH
// i/o port addresses of the two registers
`define SLDLC_LED_PORT_ADDR 16'h01D0
`define SLDLC_XCVR_CTRL_ADDR 16'h01D3
// field positions in the transceiver control register
`define SLDLC_RS422_TX_BIT 0
`define SLDLC_RX_BIT 1
`define SLDLC_RS485_TX_BIT 2
// mask of the implemented transceiver bits
`define SLDLC_XCVR_MASK 8'h07
// field position of the led bit in the led port
`define SLDLC_LED_BIT 7
// reset values: all drivers off, receiver off, led off
`define SLDLC_XCVR_RESET 3'h0
`define SLDLC_LED_RESET 1'h0
// read data after reset, nothing read yet
`define SLDLC_RDATA_RESET 8'h00
`endif

// [verilog/sldlc_pkg.sv]
package sldlc_pkg;
   // i/o port address type
   typedef logic [15:0] sldlc_addr_t;
   // 8-bit data byte
   typedef logic [7:0] sldlc_byte_t;
endpackage

// [verilog/sldlc_top.sv]
`timescale 1ns/1ps
`include "sldlc_defines.svh"

module sldlc_top
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // host i/o port access, one cycle strobes
   input wire sldlc_pkg::sldlc_addr_t io_addr_i,
   input wire logic io_wr_i,
   input wire logic io_rd_i,
   input wire sldlc_pkg::sldlc_byte_t io_wdata_i,
   output sldlc_pkg::sldlc_byte_t io_rdata_o,
   output logic io_hit_o,
   // transceiver enables
   output logic rs485_tx_enable_o,
   output logic line_rx_enable_o,
   output logic rs422_tx_enable_o,
   // led drive, high means lit
   output logic led_on_o
);

   // stored transceiver bits, bit order as in the register
   logic [2:0] xcvr_r;
   logic [2:0] xcvr_nxt;
   // stored led bit
   logic led_r;
   logic led_nxt;
   // registered read data
   sldlc_pkg::sldlc_byte_t rdata_r;
   sldlc_pkg::sldlc_byte_t rdata_nxt;
   // address decodes
   logic sel_xcvr;
   logic sel_led;

   assign sel_xcvr = (io_addr_i == `SLDLC_XCVR_CTRL_ADDR);
   assign sel_led = (io_addr_i == `SLDLC_LED_PORT_ADDR);

   // next-state of the control bits: only a write moves them, so the
   // line never turns around by itself (half-duplex is software paced)
   always_comb
   begin
      xcvr_nxt = xcvr_r;
      led_nxt = led_r;
      if (io_wr_i && sel_xcvr)
      begin
         // reserved bits 7..3 dropped here
         xcvr_nxt = io_wdata_i[2:0];
      end
      if (io_wr_i && sel_led)
      begin
         // other led port bits have no storage in this block, so they
         // read back as zero and a read-modify-write keeps them zero
         led_nxt = io_wdata_i[`SLDLC_LED_BIT];
      end
   end

   // read mux; unmapped addresses read zero
   always_comb
   begin
      rdata_nxt = rdata_r;
      if (io_rd_i)
      begin
         rdata_nxt = 8'h00;
         if (sel_xcvr)
         begin
            rdata_nxt = {5'h00, xcvr_r};
         end
         else if (sel_led)
         begin
            // led bit reads back so read-modify-write keeps it
            rdata_nxt = {led_r, 7'h00};
         end
      end
   end

   // control flops; reset leaves every driver off, so the line is quiet
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         xcvr_r <= `SLDLC_XCVR_RESET;
         led_r <= `SLDLC_LED_RESET;
      end
      else
      begin
         xcvr_r <= xcvr_nxt;
         led_r <= led_nxt;
      end
   end

   // read data flop, kept apart so a read never touches the enables
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rdata_r <= `SLDLC_RDATA_RESET;
      end
      else
      begin
         rdata_r <= rdata_nxt;
      end
   end

   // outputs straight from the flops, except io_hit_o, decoded from the address
   assign rs485_tx_enable_o = xcvr_r[`SLDLC_RS485_TX_BIT];
   assign line_rx_enable_o = xcvr_r[`SLDLC_RX_BIT];
   assign rs422_tx_enable_o = xcvr_r[`SLDLC_RS422_TX_BIT];
   assign led_on_o = led_r;
   assign io_rdata_o = rdata_r;
   assign io_hit_o = sel_xcvr | sel_led;

   // transmit bit follows a write of bit two one cycle later
   property p_tx485_write;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (io_wr_i && sel_xcvr) |=> (rs485_tx_enable_o == $past(io_wdata_i[2]));
   endproperty
   a_tx485_write: assert property (p_tx485_write)
      else $error("rs485 tx enable did not follow write");

   // clearing bit two drops transmit, line released
   property p_tx485_clear;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (io_wr_i && sel_xcvr && !io_wdata_i[2]) |=> !rs485_tx_enable_o;
   endproperty
   a_tx485_clear: assert property (p_tx485_clear)
      else $error("rs485 tx still on after clear");

   // receive bit
   property p_rx_write;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (io_wr_i && sel_xcvr) |=> (line_rx_enable_o == $past(io_wdata_i[1]));
   endproperty
   a_rx_write: assert property (p_rx_write)
      else $error("rx enable did not follow write");

   // rs422 transmit bit
   property p_tx422_write;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (io_wr_i && sel_xcvr) |=> (rs422_tx_enable_o == $past(io_wdata_i[0]));
   endproperty
   a_tx422_write: assert property (p_tx422_write)
      else $error("rs422 tx enable did not follow write");

   // no write means no change of any enable
   property p_no_auto_turn;
      @(posedge mclk_i) disable iff (!rst_n_i)
      !(io_wr_i && sel_xcvr) |=> $stable(xcvr_r);
   endproperty
   a_no_auto_turn: assert property (p_no_auto_turn)
      else $error("enables changed without a write");

   // reserved bits read zero, low bits read stored value
   property p_readback;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (io_rd_i && sel_xcvr) |=> (io_rdata_o == {5'h00, $past(xcvr_r)});
   endproperty
   a_readback: assert property (p_readback)
      else $error("transceiver readback wrong");

   // reserved write bits do not disturb the enables
   property p_reserved;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (io_wr_i && sel_xcvr) |=>
         ({5'h00, xcvr_r} == $past(io_wdata_i & `SLDLC_XCVR_MASK));
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved bits reached an enable");

   // led follows bit seven of a led port write
   property p_led;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (io_wr_i && sel_led) |=> (led_on_o == $past(io_wdata_i[7]));
   endproperty
   a_led: assert property (p_led)
      else $error("led did not follow write");

   // led readback keeps its value for read-modify-write
   property p_led_read;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (io_rd_i && sel_led) |=> (io_rdata_o == {$past(led_r), 7'h00});
   endproperty
   a_led_read: assert property (p_led_read)
      else $error("led readback wrong");

   // setting bit two turns the half-duplex driver on
   property p_tx485_set;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (io_wr_i && sel_xcvr && io_wdata_i[2]) |=> rs485_tx_enable_o;
   endproperty
   a_tx485_set: assert property (p_tx485_set)
      else $error("rs485 tx not on after set");

   // read data stands until the next read strobe
   property p_rdata_stands;
      @(posedge mclk_i) disable iff (!rst_n_i)
      !io_rd_i |=> $stable(io_rdata_o);
   endproperty
   a_rdata_stands: assert property (p_rdata_stands)
      else $error("read data changed without a read");

   // reads of unmapped ports return zero
   property p_unmapped_read;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (io_rd_i && !io_hit_o) |=> (io_rdata_o == 8'h00);
   endproperty
   a_unmapped_read: assert property (p_unmapped_read)
      else $error("unmapped read not zero");

   // led holds unless its own port is written
   property p_led_hold;
      @(posedge mclk_i) disable iff (!rst_n_i)
      !(io_wr_i && sel_led) |=> $stable(led_on_o);
   endproperty
   a_led_hold: assert property (p_led_hold)
      else $error("led changed without a led write");

endmodule // sldlc_top
